// [verilog/rvs_map.svh]
// Register offsets, field positions and reset values of the rail code bank
`ifndef RVS_MAP_SVH
`define RVS_MAP_SVH

`define RVS_OFS_SD6         8'h99
`define RVS_OFS_LR2         8'h9a
`define RVS_OFS_LR3         8'h9b
`define RVS_RD_UNMAPPED     8'h00

`define RVS_SD6_HI          7
`define RVS_SD6_LO          1
`define RVS_SD6_RSVD        0
`define RVS_SD6_RSVD_VAL    1'h0
`define RVS_SLP_HI          7
`define RVS_SLP_LO          4
`define RVS_NRM_HI          3
`define RVS_NRM_LO          0

`define RVS_SD6_W           7
`define RVS_LR_W            4
`define RVS_RAILS           3

`define RVS_RAIL_SD6        0
`define RVS_RAIL_LR2        1
`define RVS_RAIL_LR3        2

`define RVS_RST_SD6_V0      8'hbe
`define RVS_RST_SD6_V1      8'h8c
`define RVS_RST_SD6_V2      8'h70
`define RVS_RST_SD6_V3      8'h4c
`define RVS_RST_LR2_V0      8'hff
`define RVS_RST_LR2_V1      8'haa
`define RVS_RST_LR2_V2      8'haa
`define RVS_RST_LR2_V3      8'h00
`define RVS_RST_LR3_V0      8'haa
`define RVS_RST_LR3_V1      8'haa
`define RVS_RST_LR3_V2      8'haa
`define RVS_RST_LR3_V3      8'h00

`endif

// [verilog/rvs_pkg.sv]
// Types and reset lookup shared by the rail code bank
package rvs_pkg;
`include "rvs_map.svh"

	typedef struct packed {
		logic [`RVS_RAILS-1:0]  sync1;
		logic [`RVS_RAILS-1:0]  sync2;
		logic [`RVS_RAILS-1:0]  sync3;
		logic [`RVS_RAILS-1:0]  sleep;
		logic [`RVS_SD6_W-1:0]  sd6_reg;
		logic [7:0]             lr2_reg;
		logic [7:0]             lr3_reg;
		logic [7:0]             rd_data;
		logic                   rd_valid;
	} rvs_top_s;

	// Variant index 0..3 picks one column of the reset table
	function automatic logic [7:0] rvs_rst_val(input int variant,
		input int rail);
		logic [7:0] v;
		v = 8'h00;
		case (rail)
			`RVS_RAIL_SD6:
				v = (variant == 0) ? `RVS_RST_SD6_V0 :
				    (variant == 1) ? `RVS_RST_SD6_V1 :
				    (variant == 2) ? `RVS_RST_SD6_V2 : `RVS_RST_SD6_V3;
			`RVS_RAIL_LR2:
				v = (variant == 0) ? `RVS_RST_LR2_V0 :
				    (variant == 1) ? `RVS_RST_LR2_V1 :
				    (variant == 2) ? `RVS_RST_LR2_V2 : `RVS_RST_LR2_V3;
			default:
				v = (variant == 0) ? `RVS_RST_LR3_V0 :
				    (variant == 1) ? `RVS_RST_LR3_V1 :
				    (variant == 2) ? `RVS_RST_LR3_V2 : `RVS_RST_LR3_V3;
		endcase
		return v;
	endfunction
endpackage

// [verilog/rvs_rail_if.sv]
// Code pair and mode of one rail, passed to its code selector
`timescale 1ns/1ns
interface rvs_rail_if #(parameter int W = 4);
	logic [W-1:0] sleep_code;
	logic [W-1:0] normal_code;
	logic         sleep;
	logic [W-1:0] applied;

	modport ctrl (output sleep_code, output normal_code, output sleep,
		input applied);
	modport rail (input sleep_code, input normal_code, input sleep,
		output applied);
endinterface

// [verilog/rvs_rail_sel.sv]
// Registered choice of sleep or normal code for one rail
`timescale 1ns/1ns
module rvs_rail_sel #(parameter int W = 4)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Rail codes
	rvs_rail_if.rail rif
);
	typedef struct packed {
		logic [W-1:0] applied;
	} rvs_sel_s;

	rvs_sel_s sel_r;
	rvs_sel_s sel_nxt;

	always_comb
	begin
		sel_nxt = sel_r;
		sel_nxt.applied = rif.sleep ? rif.sleep_code : rif.normal_code; // RQ6
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			sel_r <= '0;
		else
			sel_r <= sel_nxt;
	end

	assign rif.applied = sel_r.applied;

	AST_APPLY: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ6
		$stable(rif.sleep) && $stable(rif.sleep_code)
			&& $stable(rif.normal_code)
		|=> rif.applied == ($past(rif.sleep) ? $past(rif.sleep_code)
			: $past(rif.normal_code)))
		else $error("applied code does not follow the rail mode");
endmodule

// [verilog/rvs_regs.sv]
// Voltage code registers for step-down rail six and linear rails two, three
//
// Behaviour
// RQ1: Step-down six sleep code bits 7:1, bit0 zero
// RQ2: Linear two sleep code in bits 7:4
// RQ3: Linear two normal code in bits 3:0
// RQ4: Linear three sleep code in bits 7:4
// RQ5: Linear three normal code in bits 3:0
// RQ6: Apply sleep code in sleep; variant reset values
`timescale 1ns/1ns
module rvs_regs
	import rvs_pkg::*;
#(
	parameter int VARIANT = 0
)
(
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	// Register port of the host interface
	input  wire logic                   reg_wr_en,
	input  wire logic                   reg_rd_en,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wr_data,
	output wire logic [7:0]             reg_rd_data,
	output wire logic                   reg_rd_valid,
	// Sleep requests per rail, from pins
	input  wire logic [`RVS_RAILS-1:0]  sleep_req,
	// Normal code of step-down six, held elsewhere
	input  wire logic [`RVS_SD6_W-1:0]  stepdown6_normal_code,
	// Codes presented to the regulators
	output wire logic [`RVS_SD6_W-1:0]  stepdown6_code,
	output wire logic [`RVS_LR_W-1:0]   linreg2_code,
	output wire logic [`RVS_LR_W-1:0]   linreg3_code
);
	localparam logic [7:0] RST_SD6 = rvs_rst_val(VARIANT, `RVS_RAIL_SD6);
	localparam logic [7:0] RST_LR2 = rvs_rst_val(VARIANT, `RVS_RAIL_LR2);
	localparam logic [7:0] RST_LR3 = rvs_rst_val(VARIANT, `RVS_RAIL_LR3);

	localparam rvs_top_s RST_S = '{
		sync1:    '0,
		sync2:    '0,
		sync3:    '0,
		sleep:    '0,
		sd6_reg:  RST_SD6[`RVS_SD6_HI:`RVS_SD6_LO],
		lr2_reg:  RST_LR2,
		lr3_reg:  RST_LR3,
		rd_data:  '0,
		rd_valid: 1'h0
	};

	rvs_top_s s_r;
	rvs_top_s s_nxt;

	rvs_rail_if #(.W(`RVS_SD6_W)) sd6_if ();
	rvs_rail_if #(.W(`RVS_LR_W))  lr2_if ();
	rvs_rail_if #(.W(`RVS_LR_W))  lr3_if ();

	always_comb
	begin
		s_nxt = s_r;
		// Pins are asynchronous; a mode change is taken only when the
		// second and third stages agree, so a one-sample glitch never flips a rail
		s_nxt.sync1 = sleep_req;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;
		for (int i = 0; i < `RVS_RAILS; i++)
		begin
			if (s_r.sync2[i] == s_r.sync3[i])
				s_nxt.sleep[i] = s_r.sync3[i]; // RQ6
		end

		if (reg_wr_en)
		begin
			case (reg_addr)
				`RVS_OFS_SD6:
					s_nxt.sd6_reg = reg_wr_data[`RVS_SD6_HI:`RVS_SD6_LO]; // RQ1
				`RVS_OFS_LR2:
					s_nxt.lr2_reg = reg_wr_data; // RQ2 RQ3
				`RVS_OFS_LR3:
					s_nxt.lr3_reg = reg_wr_data; // RQ4 RQ5
				default:
					s_nxt.lr3_reg = s_r.lr3_reg;
			endcase
		end

		// Read returns the value held before a same-cycle write
		s_nxt.rd_valid = reg_rd_en;
		if (reg_rd_en)
		begin
			case (reg_addr)
				`RVS_OFS_SD6:
					s_nxt.rd_data = {s_r.sd6_reg, `RVS_SD6_RSVD_VAL}; // RQ1
				`RVS_OFS_LR2:
					s_nxt.rd_data = s_r.lr2_reg;
				`RVS_OFS_LR3:
					s_nxt.rd_data = s_r.lr3_reg;
				default:
					s_nxt.rd_data = `RVS_RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			s_r <= RST_S; // RQ6
		else
			s_r <= s_nxt;
	end

	assign sd6_if.sleep_code  = s_r.sd6_reg;
	assign sd6_if.normal_code = stepdown6_normal_code;
	assign sd6_if.sleep       = s_r.sleep[`RVS_RAIL_SD6];
	assign lr2_if.sleep_code  = s_r.lr2_reg[`RVS_SLP_HI:`RVS_SLP_LO];
	assign lr2_if.normal_code = s_r.lr2_reg[`RVS_NRM_HI:`RVS_NRM_LO];
	assign lr2_if.sleep       = s_r.sleep[`RVS_RAIL_LR2];
	assign lr3_if.sleep_code  = s_r.lr3_reg[`RVS_SLP_HI:`RVS_SLP_LO];
	assign lr3_if.normal_code = s_r.lr3_reg[`RVS_NRM_HI:`RVS_NRM_LO];
	assign lr3_if.sleep       = s_r.sleep[`RVS_RAIL_LR3];

	rvs_rail_sel #(.W(`RVS_SD6_W)) u_sel_sd6 (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.rif     (sd6_if.rail)
	);

	rvs_rail_sel #(.W(`RVS_LR_W)) u_sel_lr2 (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.rif     (lr2_if.rail)
	);

	rvs_rail_sel #(.W(`RVS_LR_W)) u_sel_lr3 (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.rif     (lr3_if.rail)
	);

	assign stepdown6_code = sd6_if.applied;
	assign linreg2_code   = lr2_if.applied;
	assign linreg3_code   = lr3_if.applied;
	assign reg_rd_data    = s_r.rd_data;
	assign reg_rd_valid   = s_r.rd_valid;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence sd6_wr_rd;
		reg_wr_en && reg_addr == `RVS_OFS_SD6
		##1 reg_rd_en && !reg_wr_en && reg_addr == `RVS_OFS_SD6;
	endsequence

	sequence lr2_wr_rd;
		reg_wr_en && reg_addr == `RVS_OFS_LR2
		##1 reg_rd_en && !reg_wr_en && reg_addr == `RVS_OFS_LR2;
	endsequence

	sequence lr3_wr_rd;
		reg_wr_en && reg_addr == `RVS_OFS_LR3
		##1 reg_rd_en && !reg_wr_en && reg_addr == `RVS_OFS_LR3;
	endsequence

	AST_SD6_RSVD: assert property ( // RQ1
		reg_rd_en && reg_addr == `RVS_OFS_SD6
		|=> reg_rd_valid && reg_rd_data[`RVS_SD6_RSVD] == `RVS_SD6_RSVD_VAL)
		else $error("reserved bit of step-down six reads nonzero");

	AST_SD6_WR: assert property ( // RQ1
		sd6_wr_rd |=> reg_rd_data[`RVS_SD6_HI:`RVS_SD6_LO]
			== $past(reg_wr_data[`RVS_SD6_HI:`RVS_SD6_LO], 2))
		else $error("step-down six sleep code not stored");

	AST_LR2_SLP: assert property ( // RQ2
		lr2_wr_rd |=> reg_rd_data[`RVS_SLP_HI:`RVS_SLP_LO]
			== $past(reg_wr_data[`RVS_SLP_HI:`RVS_SLP_LO], 2))
		else $error("linear two sleep code not stored");

	AST_LR2_NRM: assert property ( // RQ3
		lr2_wr_rd |=> reg_rd_data[`RVS_NRM_HI:`RVS_NRM_LO]
			== $past(reg_wr_data[`RVS_NRM_HI:`RVS_NRM_LO], 2))
		else $error("linear two normal code not stored");

	AST_LR3_SLP: assert property ( // RQ4
		lr3_wr_rd |=> reg_rd_data[`RVS_SLP_HI:`RVS_SLP_LO]
			== $past(reg_wr_data[`RVS_SLP_HI:`RVS_SLP_LO], 2))
		else $error("linear three sleep code not stored");

	AST_LR3_NRM: assert property ( // RQ5
		lr3_wr_rd |=> reg_rd_data[`RVS_NRM_HI:`RVS_NRM_LO]
			== $past(reg_wr_data[`RVS_NRM_HI:`RVS_NRM_LO], 2))
		else $error("linear three normal code not stored");

	AST_PIN_FILT: assert property ( // RQ6
		sleep_req[`RVS_RAIL_LR2] [*4] |=> s_r.sleep[`RVS_RAIL_LR2])
		else $error("steady sleep request not taken in four cycles");

	// Pin stages need two steady samples before the mode may move; it moves two edges after the second
	sequence sd6_req_held;
		sleep_req[`RVS_RAIL_SD6] [*4];
	endsequence

	sequence lr2_req_quiet;
		(!sleep_req[`RVS_RAIL_LR2]) [*4];
	endsequence

	AST_SD6_FILT: assert property ( // RQ6
		sd6_req_held |=> s_r.sleep[`RVS_RAIL_SD6])
		else $error("steady step-down six request not taken");

	AST_PIN_DROP: assert property ( // RQ6
		lr2_req_quiet |=> !s_r.sleep[`RVS_RAIL_LR2])
		else $error("steady release of linear two not taken");

	AST_RD_UNMAP: assert property ( // RQ1
		reg_rd_en && reg_addr != `RVS_OFS_SD6
			&& reg_addr != `RVS_OFS_LR2 && reg_addr != `RVS_OFS_LR3
		|=> reg_rd_data == `RVS_RD_UNMAPPED)
		else $error("unmapped offset reads nonzero");

	// Stray writes must leave every code untouched
	AST_WR_UNMAP: assert property ( // RQ1
		reg_wr_en && reg_addr != `RVS_OFS_SD6
			&& reg_addr != `RVS_OFS_LR2 && reg_addr != `RVS_OFS_LR3
		|=> $stable(s_r.sd6_reg) && $stable(s_r.lr2_reg)
			&& $stable(s_r.lr3_reg))
		else $error("write to unmapped offset changed a code");

	AST_RD_PULSE: assert property ( // RQ1
		!reg_rd_en |=> !reg_rd_valid)
		else $error("read valid without a read strobe");
endmodule

// [tb/rvs_regs_tb_top.sv]
// Self-checking bench for the rail voltage code register bank
`timescale 1ns/1ns
`include "rvs_map.svh"

`define RVS_CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
		end \
	end

module rvs_regs_tb_top;
	logic       ref_clk;
	logic       resetn;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wr_data;
	wire  [7:0] reg_rd_data;
	wire        reg_rd_valid;
	logic [2:0] sleep_req;
	logic [6:0] sd6_norm;
	wire  [6:0] stepdown6_code;
	wire  [3:0] linreg2_code;
	wire  [3:0] linreg3_code;
	int         fail_count;
	int         comparisons;
	int         cycles;

	rvs_regs #(.VARIANT(0)) uut
	(
		.ref_clk               (ref_clk),
		.resetn                (resetn),
		.reg_wr_en             (reg_wr_en),
		.reg_rd_en             (reg_rd_en),
		.reg_addr              (reg_addr),
		.reg_wr_data           (reg_wr_data),
		.reg_rd_data           (reg_rd_data),
		.reg_rd_valid          (reg_rd_valid),
		.sleep_req             (sleep_req),
		.stepdown6_normal_code (sd6_norm),
		.stepdown6_code        (stepdown6_code),
		.linreg2_code          (linreg2_code),
		.linreg3_code          (linreg3_code)
	);

	initial
	begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Strobes rise one step after an edge and drop one cycle later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_wr_en = 1'h1;
		reg_addr = a;
		reg_wr_data = d;
		@(posedge ref_clk);
		#1;
		reg_wr_en = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		#1;
		reg_rd_en = 1'h1;
		reg_addr = a;
		@(posedge ref_clk);
		#1;
		reg_rd_en = 1'h0;
		`RVS_CHK(reg_rd_valid, 1'h1)
		`RVS_CHK(reg_rd_data, exp)
	endtask

	// Write then read the same offset on the very next edge
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		@(posedge ref_clk);
		#1;
		reg_wr_en = 1'h1;
		reg_addr = a;
		reg_wr_data = d;
		@(posedge ref_clk);
		#1;
		reg_wr_en = 1'h0;
		reg_rd_en = 1'h1;
		@(posedge ref_clk);
		#1;
		reg_rd_en = 1'h0;
		`RVS_CHK(reg_rd_valid, 1'h1)
		`RVS_CHK(reg_rd_data, exp)
	endtask

	task automatic codes(input logic [6:0] s6, input logic [3:0] l2,
		input logic [3:0] l3);
		`RVS_CHK(stepdown6_code, s6)
		`RVS_CHK(linreg2_code, l2)
		`RVS_CHK(linreg3_code, l3)
	endtask

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			close_out();
		end
	end

	initial
	begin
		resetn = 1'h0;
		reg_wr_en = 1'h0;
		reg_rd_en = 1'h0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
		sleep_req = 3'h0;
		sd6_norm = 7'h2a;
		repeat (4) @(posedge ref_clk);
		#1;
		resetn = 1'h1;

		rd(`RVS_OFS_SD6, 8'hbe);
		rd(`RVS_OFS_LR2, 8'hff);
		rd(`RVS_OFS_LR3, 8'haa);
		codes(7'h2a, 4'hf, 4'ha);
		$display("test reset values done");

		wr_rd(`RVS_OFS_SD6, 8'h3b, 8'h3a);
		wr_rd(`RVS_OFS_LR2, 8'h71, 8'h71);
		wr_rd(`RVS_OFS_LR3, 8'h1e, 8'h1e);
		wr(`RVS_OFS_SD6, 8'hff);
		rd(`RVS_OFS_SD6, 8'hfe);
		wr(`RVS_OFS_SD6, 8'h01);
		rd(`RVS_OFS_SD6, 8'h00);
		wr(`RVS_OFS_SD6, 8'h81);
		wr(`RVS_OFS_LR2, 8'h5c);
		rd(`RVS_OFS_LR2, 8'h5c);
		wr(`RVS_OFS_LR3, 8'ha3);
		rd(`RVS_OFS_LR3, 8'ha3);
		codes(7'h2a, 4'hc, 4'h3);
		$display("test write and read done");

		wr(8'h9c, 8'h55);
		wr(8'h98, 8'h66);
		rd(8'h9c, 8'h00);
		rd(8'h98, 8'h00);
		rd(`RVS_OFS_SD6, 8'h80);
		rd(`RVS_OFS_LR2, 8'h5c);
		rd(`RVS_OFS_LR3, 8'ha3);
		$display("test unmapped access done");

		@(posedge ref_clk);
		#1;
		sleep_req = 3'h7;
		repeat (6) @(posedge ref_clk);
		#1;
		codes(7'h40, 4'h5, 4'ha);
		sleep_req = 3'h2;
		repeat (6) @(posedge ref_clk);
		#1;
		codes(7'h2a, 4'h5, 4'h3);
		wr(`RVS_OFS_LR2, 8'h9c);
		@(posedge ref_clk);
		#1;
		codes(7'h2a, 4'h9, 4'h3);
		sleep_req = 3'h5;
		repeat (6) @(posedge ref_clk);
		#1;
		codes(7'h40, 4'hc, 4'ha);
		$display("test sleep selection done");

		// Reset mid-run must bring back the variant values
		@(posedge ref_clk);
		#1;
		sleep_req = 3'h0;
		resetn = 1'h0;
		repeat (2) @(posedge ref_clk);
		#1;
		resetn = 1'h1;
		rd(`RVS_OFS_SD6, 8'hbe);
		rd(`RVS_OFS_LR2, 8'hff);
		rd(`RVS_OFS_LR3, 8'haa);
		codes(7'h2a, 4'hf, 4'ha);
		$display("test mid-run reset done");

		close_out();
	end
endmodule
